//--- shared/adc_readout_pkg.sv
// Purpose: Shared constants for the converter result readout block.
// Assumes: Byte-wide I/O bus with separate read and write strobes.
// Notes:   Port addresses are the printed I/O addresses.
`default_nettype none
package adc_readout_pkg;
   localparam logic [9:0]  RESULT_LOW_ADDR  = 10'h304;
   localparam logic [9:0]  RESULT_HIGH_ADDR = 10'h305;
   localparam logic [9:0]  TRIGGER_ADDR     = 10'h306;
   localparam logic [9:0]  OFFSET_TRIM_ADDR = 10'h307;
   localparam logic [7:0]  OFFSET_TRIM_RST  = 8'h80;
   localparam logic [7:0]  TRIGGER_CLEAR    = 8'h00;
   localparam logic [15:0] RESULT_RST       = 16'h0000;
   localparam int          DONE_BIT         = 6;
   localparam int          SPI_DIV          = 8;
endpackage
`default_nettype wire

//--- rtl/offset_trim_spi.sv
// Purpose: Shift an 8-bit wiper value out to the offset potentiometer.
// Assumes: Potentiometer latches MSB-first data on rising clock, select low.
// Notes:   One transfer at a time; a new value during a transfer is resent.
`default_nettype none
module offset_trim_spi #(
   parameter int DIV = adc_readout_pkg::SPI_DIV
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       load,
   input  wire logic [7:0] value,
   output var  logic       pot_sclk,
   output var  logic       pot_sdata,
   output var  logic       pot_csel_n
);
   typedef enum logic [1:0] {IDLE, LOW, HIGH} spi_state_type;
   spi_state_type state_q, state_d;
   logic [7:0]  shift_q, shift_d;
   logic [3:0]  bits_q, bits_d;
   logic [7:0]  div_q, div_d;
   logic        pend_q, pend_d;
   logic [7:0]  pval_q, pval_d;
   logic        tick;

   // --------------------------------------------------------------
   // Serial engine
   // --------------------------------------------------------------
   // Divider tick paces each half bit
   assign tick = (div_q == 8'(DIV - 1));

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      bits_d  = bits_q;
      div_d   = (state_q == IDLE || tick) ? 8'h00 : div_q + 8'h01;
      pend_d  = pend_q | load;
      pval_d  = load ? value : pval_q;
      case (state_q)
         IDLE: begin
            if (pend_q) begin
               state_d = LOW;
               shift_d = pval_q;
               bits_d  = 4'h0;
               pend_d  = load;
            end
         end
         LOW:  if (tick) state_d = HIGH;
         HIGH: begin
            if (tick) begin
               shift_d = {shift_q[6:0], 1'b0};
               bits_d  = bits_q + 4'h1;
               state_d = (bits_q == 4'h7) ? IDLE : LOW;
            end
         end
         default: state_d = IDLE;
      endcase
   end

   // Registers only; outputs decoded from flops below
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= IDLE;
         shift_q <= 8'h00;
         bits_q  <= 4'h0;
         div_q   <= 8'h00;
         pend_q  <= 1'b1;          // Push the reset midpoint once
         pval_q  <= adc_readout_pkg::OFFSET_TRIM_RST;
         pot_sclk   <= 1'b0;
         pot_sdata  <= 1'b0;
         pot_csel_n <= 1'b1;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         bits_q  <= bits_d;
         div_q   <= div_d;
         pend_q  <= pend_d;
         pval_q  <= pval_d;
         pot_sclk   <= (state_d == HIGH);
         pot_sdata  <= shift_d[7];
         pot_csel_n <= (state_d == IDLE);
      end
   end
endmodule
`default_nettype wire

//--- rtl/adc_result_readout.sv
// Purpose: Result readout ports, high-byte side effects and offset trim.
// Assumes: Bus inputs synchronous to ref_clk; one strobe per bus cycle.
// Notes:   Converter sequencing lives elsewhere; it hands results in here.
//
// Summary of operation
// [R1] High port read returns result bits 15..8.
// [R2] Low port read returns result bits 7..0.
// [R3] Host reads low byte before high byte.
// [R4] A high port read clears the completion flag unless a completion arrives in the same cycle.
// [R5] With DMA off, a high port read drops the interrupt request.
// [R6] With channel stepping on, a high read advances the multiplexer.
// [R7] With auto trigger on, a high read starts a new conversion.
// [R8] Word read at the low address returns both bytes with high effects.
// [R9] Results are two's complement; zero is 0000h, minus one FFFFh.
// [R10] Input span is 65536 equal steps, sign follows input.
// [R11] Offset trim write sets the 8-bit wiper; it is write-only.
// [R12] Trim full range moves the result about plus or minus 00B0h.
// [R13] Trim is offset binary: FFh lowest, 80h none, 00h highest.
// [R14] Board reset returns trim to 80h.
// [R15] Completion flag is status D6; sets interrupt when enabled. With DMA on, the code raises the request on dma_terminal, not on completion.
// [R16] In DMA mode the request clears only by writing 00h to trigger.
// [R17] High read side effects happen once per read cycle, on strobe.
`default_nettype none
module adc_result_readout #(
   parameter int RESULT_W = 16,
   parameter int CHAN_W   = 4
) (
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic [9:0]          bus_addr,
   input  wire logic                bus_rd,
   input  wire logic                bus_wr,
   input  wire logic                bus_word,
   input  wire logic [7:0]          bus_wdata,
   input  wire logic                conv_done,
   input  wire logic [RESULT_W-1:0] conv_result,
   input  wire logic                int_enable,
   input  wire logic                dma_enable_bit,
   input  wire logic                auto_trigger_enable,
   input  wire logic                chan_step_enable,
   input  wire logic                dma_terminal,
   output var  logic [15:0]         bus_rdata,
   output var  logic                bus_rvalid,
   output var  logic                done_flag,
   output var  logic                conv_irq,
   output var  logic                chan_advance,
   output var  logic                conv_start,
   output var  logic [7:0]          offset_trim_reg,
   output var  logic                pot_sclk,
   output var  logic                pot_sdata,
   output var  logic                pot_csel_n
);
   logic [RESULT_W-1:0] result_q, result_d;
   logic [15:0]         rdata_d;
   logic                rvalid_d;
   logic                done_d, irq_d, adv_d, start_d;
   logic [7:0]          trim_d;
   logic                rd_q;
   logic                rd_edge;
   logic                hi_read;
   logic                trig_clear;
   logic                trim_load_q;

   // Address match used by both read and write decode
   function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
      hit = (a == ref_a);
   endfunction

   // --------------------------------------------------------------
   // Read strobe and decode
   // --------------------------------------------------------------
   // Edge of the strobe so a long read fires effects only once
   assign rd_edge = bus_rd & ~rd_q;                                  // see [R17]
   assign hi_read = rd_edge & (hit(bus_addr, adc_readout_pkg::RESULT_HIGH_ADDR)
                  | (bus_word & hit(bus_addr, adc_readout_pkg::RESULT_LOW_ADDR))); // see [R8]
   assign trig_clear = bus_wr & hit(bus_addr, adc_readout_pkg::TRIGGER_ADDR)
                     & (bus_wdata == adc_readout_pkg::TRIGGER_CLEAR);

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   // Result is stored raw; coding is the converter's two's complement
   always_comb begin
      result_d = conv_done ? conv_result : result_q;                 // see [R9] [R10]
      rvalid_d = rd_edge;
      rdata_d  = 16'h0000;
      if (rd_edge) begin
         if (hit(bus_addr, adc_readout_pkg::RESULT_LOW_ADDR))
            rdata_d = bus_word ? result_q[15:0]                      // see [R8]
                               : {8'h00, result_q[7:0]};             // see [R2]
         else if (hit(bus_addr, adc_readout_pkg::RESULT_HIGH_ADDR))
            rdata_d = {8'h00, result_q[15:8]};                       // see [R1]
      end
      // Set wins over a clear in the same cycle
      done_d = conv_done | (done_flag & ~hi_read);                   // see [R4] [R15]
      irq_d  = conv_irq;
      if (hi_read & ~dma_enable_bit)
         irq_d = 1'b0;                                               // see [R5]
      if (trig_clear)
         irq_d = 1'b0;                                               // see [R16]
      if (int_enable & ~dma_enable_bit & conv_done)
         irq_d = 1'b1;                                               // see [R15]
      if (int_enable & dma_enable_bit & dma_terminal)
         irq_d = 1'b1;
      adv_d   = hi_read & chan_step_enable;                          // see [R6]
      start_d = hi_read & auto_trigger_enable;                       // see [R7]
      trim_d  = offset_trim_reg;
      if (bus_wr & hit(bus_addr, adc_readout_pkg::OFFSET_TRIM_ADDR))
         trim_d = bus_wdata;                                         // see [R11] [R13]
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_q        <= adc_readout_pkg::RESULT_RST;
         rd_q            <= 1'b0;
         bus_rdata       <= 16'h0000;
         bus_rvalid      <= 1'b0;
         done_flag       <= 1'b0;
         conv_irq        <= 1'b0;
         chan_advance    <= 1'b0;
         conv_start      <= 1'b0;
         offset_trim_reg <= adc_readout_pkg::OFFSET_TRIM_RST;        // see [R14]
         trim_load_q     <= 1'b0;
      end else begin
         result_q        <= result_d;
         rd_q            <= bus_rd;
         bus_rdata       <= rdata_d;
         bus_rvalid      <= rvalid_d;
         done_flag       <= done_d;
         conv_irq        <= irq_d;
         chan_advance    <= adv_d;
         conv_start      <= start_d;
         offset_trim_reg <= trim_d;
         trim_load_q     <= (trim_d != offset_trim_reg);
      end
   end

   // --------------------------------------------------------------
   // Potentiometer link
   // --------------------------------------------------------------
   // Analog shift of about 00B0h per half range is set by the pot itself
   offset_trim_spi #(.DIV(adc_readout_pkg::SPI_DIV)) u_trim (        // see [R12]
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .load       (trim_load_q),
      .value      (offset_trim_reg),
      .pot_sclk   (pot_sclk),
      .pot_sdata  (pot_sdata),
      .pot_csel_n (pot_csel_n)
   );

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_high_read;
      rd_edge && bus_addr == adc_readout_pkg::RESULT_HIGH_ADDR;
   endsequence

   property p_high_data;
      @(posedge ref_clk) disable iff (sys_rst)
      s_high_read |=> bus_rvalid && bus_rdata == {8'h00, $past(result_q[15:8])};
   endproperty
   a_high_data: assert property (p_high_data) else $error("high byte wrong"); // see [R1]

   property p_low_data;
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_edge && !bus_word && bus_addr == adc_readout_pkg::RESULT_LOW_ADDR)
         |=> bus_rdata == {8'h00, $past(result_q[7:0])};
   endproperty
   a_low_data: assert property (p_low_data) else $error("low byte wrong"); // see [R2]

   property p_done_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (hi_read && !conv_done) |=> !done_flag;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done not cleared"); // see [R4]

   property p_irq_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (hi_read && !dma_enable_bit && !conv_done) |=> !conv_irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared"); // see [R5]

   property p_advance;
      @(posedge ref_clk) disable iff (sys_rst)
      (hi_read && chan_step_enable) |=> chan_advance ##1 !chan_advance;
   endproperty
   a_advance: assert property (p_advance) else $error("no channel step"); // see [R6]

   property p_autotrig;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(conv_start) |-> $past(hi_read) && $past(auto_trigger_enable);
   endproperty
   a_autotrig: assert property (p_autotrig) else $error("bad auto trigger"); // see [R7]

   property p_word;
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_edge && bus_word && bus_addr == adc_readout_pkg::RESULT_LOW_ADDR && !conv_done)
         |=> bus_rdata == $past(result_q) && !done_flag;
   endproperty
   a_word: assert property (p_word) else $error("word read wrong"); // see [R8]

   property p_dma_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      (conv_irq && dma_enable_bit && !trig_clear) |=> conv_irq;
   endproperty
   a_dma_hold: assert property (p_dma_hold) else $error("dma irq dropped"); // see [R16]

   property p_done_set;
      @(posedge ref_clk) disable iff (sys_rst)
      conv_done |=> done_flag;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done not set"); // see [R15]

   property p_once;
      @(posedge ref_clk) disable iff (sys_rst)
      bus_rd && $past(bus_rd) |-> !hi_read;
   endproperty
   a_once: assert property (p_once) else $error("repeat side effect"); // see [R17]

   property p_trim;
      @(posedge ref_clk) disable iff (sys_rst)
      (bus_wr && bus_addr == adc_readout_pkg::OFFSET_TRIM_ADDR)
         |=> offset_trim_reg == $past(bus_wdata);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not stored"); // see [R11]

   // --------------------------------------------------------------
   // Further checks on requests, pulses and the pot link
   // --------------------------------------------------------------
   // Completion raises the request only while interrupts are on
   property p_irq_set;
      @(posedge ref_clk) disable iff (sys_rst)
      (int_enable && !dma_enable_bit && conv_done) |=> conv_irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq not set"); // see [R15]

   property p_irq_needs_int;
      @(posedge ref_clk) disable iff (sys_rst)
      (!int_enable && !conv_irq) |=> !conv_irq;
   endproperty
   a_irq_needs_int: assert property (p_irq_needs_int) else $error("irq no enable"); // see [R15]

   // Zero written to the trigger port drops the request
   property p_trig_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (trig_clear && !conv_done && !dma_terminal) |=> !conv_irq;
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trig clear failed"); // see [R16]

   // Only a high read with DMA off may also drop it, so other trigger values leave it up
   property p_irq_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      (conv_irq && !trig_clear && !(hi_read && !dma_enable_bit)) |=> conv_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped"); // see [R5] [R16]

   // One answer per strobe edge, never a stray one
   sequence s_one_answer;
      bus_rvalid ##1 !bus_rvalid;
   endsequence

   property p_rvalid;
      @(posedge ref_clk) disable iff (sys_rst)
      rd_edge |=> s_one_answer;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("answer not one pulse"); // see [R17]

   property p_rvalid_src;
      @(posedge ref_clk) disable iff (sys_rst)
      bus_rvalid |-> $past(rd_edge);
   endproperty
   a_rvalid_src: assert property (p_rvalid_src) else $error("stray read answer"); // see [R17]

   property p_step_src;
      @(posedge ref_clk) disable iff (sys_rst)
      chan_advance |-> $past(hi_read) && $past(chan_step_enable);
   endproperty
   a_step_src: assert property (p_step_src) else $error("stray channel step"); // see [R6]

   sequence s_start_pulse;
      conv_start ##1 !conv_start;
   endsequence

   property p_start_pulse;
      @(posedge ref_clk) disable iff (sys_rst)
      (hi_read && auto_trigger_enable) |=> s_start_pulse;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("no single start"); // see [R7]

   // Trim moves only on its own write
   property p_trim_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      !(bus_wr && bus_addr == adc_readout_pkg::OFFSET_TRIM_ADDR)
         |=> $stable(offset_trim_reg);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim moved"); // see [R11]

   // Write-only trim and unused addresses read as zero
   property p_unmapped;
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_edge && bus_addr != adc_readout_pkg::RESULT_LOW_ADDR
               && bus_addr != adc_readout_pkg::RESULT_HIGH_ADDR) |=> bus_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero"); // see [R11]

   // A low byte read alone must not complete the pickup
   property p_low_keep;
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_edge && !bus_word && bus_addr == adc_readout_pkg::RESULT_LOW_ADDR && done_flag)
         |=> done_flag;
   endproperty
   a_low_keep: assert property (p_low_keep) else $error("low read cleared done"); // see [R4]

   // Pot clock rests low outside frames
   property p_pot_rest;
      @(posedge ref_clk) disable iff (sys_rst)
      pot_csel_n |-> !pot_sclk;
   endproperty
   a_pot_rest: assert property (p_pot_rest) else $error("pot clock moved idle"); // see [R11]

   // A new trim value opens a frame within a few cycles
   property p_trim_send;
      @(posedge ref_clk) disable iff (sys_rst)
      trim_load_q |-> ##[1:3] !pot_csel_n;
   endproperty
   a_trim_send: assert property (p_trim_send) else $error("trim not sent"); // see [R11]
endmodule
`default_nettype wire

//--- verification/trim_pot_model.sv
// Purpose: Behavioural offset potentiometer on the serial trim link.
// Assumes: MSB first, data taken on rising clock while select is low.
// Notes:   Only whole 8-bit frames update the wiper.
`default_nettype none
module trim_pot_model (
   input  wire logic       pot_sclk,
   input  wire logic       pot_sdata,
   input  wire logic       pot_csel_n,
   output var  logic [7:0] wiper,
   output var  int         frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift_q;
   int         bits;
   initial begin
      wiper  = 8'h00;
      frames = 0;
      bits   = 0;
   end
   // -----------------------------------------------
   // Shift in, latch on deselect
   // -----------------------------------------------
   // Short frames are dropped, as a real pot ignores them
   always @(negedge pot_csel_n) bits = 0;
   always @(posedge pot_sclk) if (pot_csel_n === 1'b0) begin
      shift_q = {shift_q[6:0], pot_sdata};
      bits++;
   end
   always @(posedge pot_csel_n) if (bits == 8) begin
      wiper = shift_q;
      frames++;
   end
endmodule
`default_nettype wire

//--- verification/adc_result_readout_tb.sv
// Purpose: Self-checking bench for the result readout block.
// Assumes: Host bus driven on falling edges; read strobe held 4 cycles.
// Notes:   Held strobe also probes once-per-cycle side effects.
`default_nettype none
module adc_result_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
   logic        ref_clk = 0, sys_rst = 1, bus_rd = 0, bus_wr = 0, bus_word = 0;
   logic [9:0]  bus_addr = '0;
   logic [7:0]  bus_wdata = '0;
   logic        conv_done = 0, int_enable = 0, dma_enable_bit = 0;
   logic        auto_trigger_enable = 0, chan_step_enable = 0, dma_terminal = 0;
   logic [15:0] conv_result = '0, bus_rdata;
   logic        bus_rvalid, done_flag, conv_irq, chan_advance, conv_start;
   logic [7:0]  offset_trim_reg, wiper;
   logic        pot_sclk, pot_sdata, pot_csel_n;
   int          frames, fails = 0, n_checks = 0, n_adv = 0, n_start = 0;
   logic [15:0] tbl [6] = '{16'h7FFF, 16'h4000, 16'h0001, 16'h0000, 16'hFFFF, 16'h8000};
   logic [7:0]  trims [3] = '{8'h00, 8'hFF, 8'h40};

   adc_result_readout dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
      .conv_done(conv_done), .conv_result(conv_result), .int_enable(int_enable),
      .dma_enable_bit(dma_enable_bit), .auto_trigger_enable(auto_trigger_enable),
      .chan_step_enable(chan_step_enable), .dma_terminal(dma_terminal),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .done_flag(done_flag),
      .conv_irq(conv_irq), .chan_advance(chan_advance), .conv_start(conv_start),
      .offset_trim_reg(offset_trim_reg), .pot_sclk(pot_sclk), .pot_sdata(pot_sdata),
      .pot_csel_n(pot_csel_n));
   trim_pot_model pot (.pot_sclk(pot_sclk), .pot_sdata(pot_sdata),
      .pot_csel_n(pot_csel_n), .wiper(wiper), .frames(frames));

   // -----------------------------------------------
   // Clock, pulse counters, hang guard
   // -----------------------------------------------
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (chan_advance === 1'b1) n_adv++;
      if (conv_start === 1'b1) n_start++;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      finish_test();
   end

   // -----------------------------------------------
   // Bus tasks
   // -----------------------------------------------
   task automatic finish_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Strobe held 4 cycles: a second answer would be a repeated effect
   task automatic rd(input logic [9:0] a, input logic w, output logic [15:0] d);
      int i, seen;
      seen = 0;
      d = '0;
      @(negedge ref_clk);
      bus_addr = a;
      bus_word = w;
      bus_rd = 1;
      for (i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         if (bus_rvalid === 1'b1) begin
            d = bus_rdata;
            seen++;
         end
      end
      bus_rd = 0;
      bus_word = 0;
      `CHK("rvalid count", 1, seen)
      if (seen == 0) finish_test();
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      bus_addr = a;
      bus_wdata = v;
      bus_wr = 1;
      @(negedge ref_clk);
      bus_wr = 0;
   endtask
   task automatic cv(input logic [15:0] r);
      @(negedge ref_clk);
      conv_result = r;
      conv_done = 1;
      @(negedge ref_clk);
      conv_done = 0;
   endtask
   task automatic wait_frame(input int f0);
      int i;
      for (i = 0; i < 400 && frames == f0; i++) @(negedge ref_clk);
      if (frames == f0) begin
         fails++;
         $display("BAD pot frame exp new got none");
         finish_test();
      end
   endtask

   // -----------------------------------------------
   // Main sequence
   // -----------------------------------------------
   initial begin
      logic [15:0] d;
      int a0, s0, f;
      repeat (4) @(negedge ref_clk);
      `CHK("trim rst", 8'h80, offset_trim_reg)
      sys_rst = 0;
      wait_frame(0);
      `CHK("pot rst", 8'h80, wiper)
      // Completion with interrupts off raises the flag only
      cv(16'h1234);
      `CHK("done no int", 1'b1, done_flag)
      `CHK("irq no int", 1'b0, conv_irq)
      int_enable = 1;
      // Signed codes across the span, low byte first
      foreach (tbl[k]) begin
         cv(tbl[k]);
         `CHK("done set", 1'b1, done_flag)
         `CHK("irq set", 1'b1, conv_irq)
         rd(10'h304, 0, d);
         `CHK("low", {8'h00, tbl[k][7:0]}, d)
         `CHK("done kept", 1'b1, done_flag)
         rd(10'h305, 0, d);
         `CHK("high", {8'h00, tbl[k][15:8]}, d)
         `CHK("done clr", 1'b0, done_flag)
         `CHK("irq clr", 1'b0, conv_irq)
      end
      cv(16'hE000);
      rd(10'h304, 1, d);
      `CHK("word", 16'hE000, d)
      `CHK("word done", 1'b0, done_flag)
      `CHK("word irq", 1'b0, conv_irq)
      // Stepping and auto trigger, then both off again
      auto_trigger_enable = 1;
      chan_step_enable = 1;
      cv(16'h2000);
      a0 = n_adv;
      s0 = n_start;
      rd(10'h304, 0, d);
      `CHK("low no step", a0, n_adv)
      rd(10'h305, 0, d);
      `CHK("step", a0 + 1, n_adv)
      `CHK("retrig", s0 + 1, n_start)
      auto_trigger_enable = 0;
      chan_step_enable = 0;
      rd(10'h305, 0, d);
      `CHK("no step", a0 + 1, n_adv)
      `CHK("no retrig", s0 + 1, n_start)
      // DMA: result read leaves the request, trigger clear drops it
      dma_enable_bit = 1;
      @(negedge ref_clk);
      dma_terminal = 1;
      @(negedge ref_clk);
      dma_terminal = 0;
      `CHK("dma irq", 1'b1, conv_irq)
      rd(10'h305, 0, d);
      `CHK("dma irq held", 1'b1, conv_irq)
      wr(10'h306, 8'h01);
      `CHK("dma irq nonzero", 1'b1, conv_irq)
      wr(10'h306, 8'h00);
      `CHK("dma irq clr", 1'b0, conv_irq)
      dma_enable_bit = 0;
      // Trim extremes and 40h, forwarded to the pot
      foreach (trims[k]) begin
         f = frames;
         wr(10'h307, trims[k]);
         `CHK("trim", trims[k], offset_trim_reg)
         wait_frame(f);
         `CHK("pot wiper", trims[k], wiper)
      end
      // Mid-run board reset drops the flags and recentres the trim
      cv(16'h1234);
      @(negedge ref_clk);
      sys_rst = 1;
      repeat (4) @(negedge ref_clk);
      `CHK("trim rst2", 8'h80, offset_trim_reg)
      `CHK("done rst", 1'b0, done_flag)
      `CHK("irq rst", 1'b0, conv_irq)
      f = frames;
      sys_rst = 0;
      wait_frame(f);
      `CHK("pot rst2", 8'h80, wiper)
      rd(10'h307, 0, d);
      `CHK("trim wo", 16'h0000, d)
      rd(10'h300, 0, d);
      `CHK("unmapped", 16'h0000, d)
      finish_test();
   end
endmodule
`default_nettype wire
